// >>> verilog/hmg_pkg.sv
/*
 * hmg_pkg: constants and types of the host interrupt mask gate.
 * assumes: one 32-bit apb slave window, byte addresses, 50 mhz clock.
 */
`default_nettype none

package hmg_pkg;

    // ----------------------------------------------------------------
    // bus geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 5;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ENABLE_SET   = 12'h088;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 12'h08c;
    localparam logic [ADDR_W-1:0] OFS_PENDING      = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_STATUS       = 12'h104;
    localparam logic [ADDR_W-1:0] OFS_TOP_SOURCE   = 12'h108;

    // ----------------------------------------------------------------
    // mask field layout
    // ----------------------------------------------------------------
    localparam int BIT_GLOBAL_GATE = 31;
    localparam int BIT_MAKER       = 30;
    // bit 28 and bits 14..10 hold no flip-flop
    localparam logic [DATA_W-1:0] MASK_RSVD    = 32'h1000_7c00;
    localparam logic [DATA_W-1:0] MASK_GATE    = 32'h8000_0000;
    localparam logic [DATA_W-1:0] MASK_SOURCES = 32'h6fff_83ff;
    localparam logic [DATA_W-1:0] MASK_RESET   = 32'h0000_0000;

    // ----------------------------------------------------------------
    // status register layout
    // ----------------------------------------------------------------
    localparam int STS_IRQ  = 0;
    localparam int STS_GATE = 1;
    localparam int STS_ANY  = 2;
    localparam int STS_VLD  = 3;

    // ----------------------------------------------------------------
    // bus slave states, gray along idle-wait-resp
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        HMG_IDLE = 2'b00,
        HMG_WAIT = 2'b01,
        HMG_RESP = 2'b11
    } hmg_apb_state_e;

endpackage : hmg_pkg

`default_nettype wire

// >>> verilog/hmg_mask_cell.sv
/*
 * hmg_mask_cell: one enable bit with separate set and clear strobes,
 * and its and-gate against the matching latched event bit.
 * assumes: strobes last one cycle and never come together.
 */
`timescale 1ns/1ps
`default_nettype none

module hmg_mask_cell #(
    parameter logic IMPL  = 1'b1,
    parameter logic RST_V = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // register side
    input  wire logic set_we,
    input  wire logic clr_we,
    input  wire logic wbit,
    // gate side
    input  wire logic evt,
    output logic      mask_q,
    output logic      hit
);

    logic mask_d;

    // a one sets on one address and clears on the other; zero keeps
    assign mask_d = IMPL & ((mask_q | (set_we & wbit))
                            & ~(clr_we & wbit));

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= RST_V & IMPL;
        end else if (ce) begin
            mask_q <= mask_d;
        end
    end

    assign hit = mask_q & evt;

endmodule : hmg_mask_cell

`default_nettype wire

// >>> verilog/hmg_prio_enc.sv
/*
 * hmg_prio_enc: registered index of the highest set request bit.
 * assumes: request vector is synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module hmg_prio_enc
    import hmg_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    // request and result
    input  wire logic [DATA_W-1:0]     req,
    output logic      [IDX_W-1:0]      idx_q,
    output logic                       valid_q
);

    logic [IDX_W-1:0] idx_d;

    // later index wins, so the highest bit has priority
    always_comb begin
        idx_d = '0;
        for (int i = 0; i < DATA_W; i++) begin
            if (req[i]) begin
                idx_d = IDX_W'(i);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            idx_q   <= '0;
            valid_q <= 1'b0;
        end else if (ce) begin
            idx_q   <= idx_d;
            valid_q <= |req;
        end
    end

endmodule : hmg_prio_enc

`default_nettype wire

// >>> verilog/hmg_top.sv
/*
 * hmg_top: host interrupt enable register with set and clear
 * addresses, per-source gating against latched events, and the
 * global gate onto one registered interrupt output.
 * assumes: latched event bits arrive on EVENT_IN from the event
 * register elsewhere; apb master follows the usual handshake.
 */
// The APB slave port is this design's own decision.
// Contract
// - reads at set or clear address both return the one enable register
// - each enable bit sits at its event bit's position, except 31
// - bit 31 off blocks the interrupt output; on, enables decide
// - maker-defined source interrupts only when enable 30 and event 30
// - software source interrupts only when enable 29 and event 29
// - bit 28 reserved: reads zero, writes ignored
// - late acknowledge source needs enable 27 and event 27
// - line-layer register received needs enable 26 and event 26
// - overlong cycle source needs enable 25 and event 25
// - fatal error source needs enable 24 and event 24
// - cycle timer mismatch needs enable 23 and event 23
// - missed cycle start needs enable 22 and event 22
// - 64-second rollover needs enable 21 and event 21
// - iso cycle start needs enable 20 and event 20
// - line-layer status transfer needs enable 19 and event 19
// - failed register access needs enable 18 and event 18
// - bus reinit needs enable 17 and event 17
// - bits 16..0 gate pairwise likewise; bits 14..10 read zero
`timescale 1ns/1ps
`default_nettype none

module hmg_top
    import hmg_pkg::*;
(
    // clock, reset, enable
    input  wire logic                  SYS_CLK,
    input  wire logic                  RESET,
    input  wire logic                  CLK_EN,
    // apb slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [ADDR_W-1:0]     PADDR,
    input  wire logic [DATA_W-1:0]     PWDATA,
    input  wire logic [3:0]            PSTRB,
    output logic      [DATA_W-1:0]     PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // latched events from the event register
    input  wire logic [DATA_W-1:0]     EVENT_IN,
    // interrupt toward the host
    output logic                       IRQ_OUT
);

    import hmg_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    hmg_apb_state_e          state_q;
    hmg_apb_state_e          state_d;
    logic [DATA_W-1:0]       rdata_q;
    logic [DATA_W-1:0]       rdata_d;
    logic                    ready_q;
    logic                    ready_d;
    logic                    err_q;
    logic                    err_d;
    logic                    irq_q;
    logic                    irq_d;
    logic [DATA_W-1:0]       pend_q;
    logic [ADDR_W-1:0]       addr_q;
    logic                    write_q;
    logic [DATA_W-1:0]       wdata_q;
    logic [3:0]              strb_q;

    wire                     access_w;
    wire                     hit_set_w;
    wire                     hit_clr_w;
    wire                     hit_pend_w;
    wire                     hit_sts_w;
    wire                     hit_top_w;
    wire                     mapped_w;
    wire                     commit_w;
    wire                     set_we_w;
    wire                     clr_we_w;
    wire [DATA_W-1:0]        lane_w;
    wire [DATA_W-1:0]        wbits_w;
    wire [DATA_W-1:0]        mask_w;
    wire [DATA_W-1:0]        hit_w;
    wire [DATA_W-1:0]        pend_w;
    wire                     any_w;
    wire                     gate_w;
    wire [DATA_W-1:0]        sts_w;
    wire [DATA_W-1:0]        top_w;
    wire [DATA_W-1:0]        rd_mux_w;
    wire [IDX_W-1:0]         top_idx_w;
    wire                     top_vld_w;

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // two wait states keep read data a clean register output
    assign access_w = PSEL & PENABLE;

    always_comb begin
        state_d = state_q;
        ready_d = 1'b0;
        unique case (state_q)
            HMG_IDLE: begin
                if (access_w) begin
                    state_d = HMG_WAIT;
                end
            end
            HMG_WAIT: begin
                state_d = HMG_RESP;
                ready_d = 1'b1;
            end
            HMG_RESP: begin
                state_d = HMG_IDLE;
            end
            default: begin
                state_d = HMG_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            state_q <= HMG_IDLE;
            ready_q <= 1'b0;
        end else if (CLK_EN) begin
            state_q <= state_d;
            ready_q <= ready_d;
        end
    end

    // request is captured once; the master holds it anyway
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            addr_q  <= '0;
            write_q <= 1'b0;
            wdata_q <= '0;
            strb_q  <= '0;
        end else if (CLK_EN && state_q == HMG_IDLE && access_w) begin
            addr_q  <= PADDR;
            write_q <= PWRITE;
            wdata_q <= PWDATA;
            strb_q  <= PSTRB;
        end
    end

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign hit_set_w  = (addr_q == OFS_ENABLE_SET);
    assign hit_clr_w  = (addr_q == OFS_ENABLE_CLEAR);
    assign hit_pend_w = (addr_q == OFS_PENDING);
    assign hit_sts_w  = (addr_q == OFS_STATUS);
    assign hit_top_w  = (addr_q == OFS_TOP_SOURCE);
    assign mapped_w   = hit_set_w | hit_clr_w | hit_pend_w
                      | hit_sts_w | hit_top_w;

    // writes land only on the edge where the master sees pready
    assign commit_w = ready_q & write_q & mapped_w;
    assign set_we_w = commit_w & hit_set_w;
    assign clr_we_w = commit_w & hit_clr_w;

    // byte strobes pick the lanes; unstrobed lanes write zero,
    // which leaves those enable bits untouched
    assign lane_w = {{8{strb_q[3]}}, {8{strb_q[2]}},
                     {8{strb_q[1]}}, {8{strb_q[0]}}};
    assign wbits_w = wdata_q & lane_w;

    // ----------------------------------------------------------------
    // enable bits and per-source gating
    // ----------------------------------------------------------------
    // the gate bit and every source bit share one cell type; reserved
    // positions elaborate without a flip-flop and read zero
    for (genvar i = 0; i < DATA_W; i++) begin : g_cell
        hmg_mask_cell #(
            .IMPL  (~MASK_RSVD[i]),
            .RST_V (MASK_RESET[i])
        ) u_cell (
            .clk    (SYS_CLK),
            .rst    (RESET),
            .ce     (CLK_EN),
            .set_we (set_we_w),
            .clr_we (clr_we_w),
            .wbit   (wbits_w[i]),
            .evt    (EVENT_IN[i]),
            .mask_q (mask_w[i]),
            .hit    (hit_w[i])
        );
    end

    // bit 31 enables, it is not a source of its own
    assign pend_w = hit_w & MASK_SOURCES;
    assign any_w  = |pend_w;
    assign gate_w = mask_w[BIT_GLOBAL_GATE];

    // ----------------------------------------------------------------
    // interrupt output
    // ----------------------------------------------------------------
    // registered, so the output trails the event or enable by a cycle
    assign irq_d = gate_w & any_w;

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            irq_q  <= 1'b0;
            pend_q <= '0;
        end else if (CLK_EN) begin
            irq_q  <= irq_d;
            pend_q <= pend_w;
        end
    end

    // ----------------------------------------------------------------
    // highest pending source, for quick dispatch by software
    // ----------------------------------------------------------------
    hmg_prio_enc u_prio (
        .clk     (SYS_CLK),
        .rst     (RESET),
        .ce      (CLK_EN),
        .req     (pend_w),
        .idx_q   (top_idx_w),
        .valid_q (top_vld_w)
    );

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    assign sts_w = (DATA_W'(irq_q)     << STS_IRQ)
                 | (DATA_W'(gate_w)    << STS_GATE)
                 | (DATA_W'(|pend_q)   << STS_ANY)
                 | (DATA_W'(top_vld_w) << STS_VLD);

    assign top_w = DATA_W'(top_idx_w);

    // both enable addresses show the same register
    assign rd_mux_w =
        ((hit_set_w | hit_clr_w) ? (mask_w & ~MASK_RSVD) : '0)
      | (hit_pend_w ? pend_q : '0)
      | (hit_sts_w  ? sts_w  : '0)
      | (hit_top_w  ? top_w  : '0);

    // unmapped addresses answer zero data with an error
    assign rdata_d = (state_q == HMG_WAIT && !write_q) ? rd_mux_w
                                                      : '0;
    assign err_d   = (state_q == HMG_WAIT) & ~mapped_w;

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rdata_q <= '0;
            err_q   <= 1'b0;
        end else if (CLK_EN) begin
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign PRDATA  = rdata_q;
    assign PREADY  = ready_q;
    assign PSLVERR = err_q;
    assign IRQ_OUT = irq_q;

endmodule : hmg_top

`default_nettype wire

// >>> bench/hmg_chk.sv
/* hmg_chk: port-level checks of the enable register and irq gate.
   assumes: bound into hmg_top; CLK_EN high while a transfer runs. */
`timescale 1ns/1ps
`default_nettype none

module hmg_chk (
    // clock and reset
    input wire logic                        SYS_CLK,
    input wire logic                        RESET,
    input wire logic                        CLK_EN,
    // apb
    input wire logic                        PSEL,
    input wire logic                        PENABLE,
    input wire logic                        PWRITE,
    input wire logic [hmg_pkg::ADDR_W-1:0]  PADDR,
    input wire logic [hmg_pkg::DATA_W-1:0]  PWDATA,
    input wire logic [3:0]                  PSTRB,
    input wire logic [hmg_pkg::DATA_W-1:0]  PRDATA,
    input wire logic                        PREADY,
    input wire logic                        PSLVERR,
    // events and interrupt
    input wire logic [hmg_pkg::DATA_W-1:0]  EVENT_IN,
    input wire logic                        IRQ_OUT
);
    import hmg_pkg::*;
    // ----------------
    // enable shadow
    // ----------------
    logic [DATA_W-1:0] en_q;
    logic [DATA_W-1:0] en_d;
    wire logic wr_hit = CLK_EN & PSEL & PENABLE & PWRITE & PREADY;
    wire logic is_set = PADDR == OFS_ENABLE_SET;
    wire logic is_en  = is_set || PADDR == OFS_ENABLE_CLEAR;
    wire logic mapped = is_en
        || PADDR inside {OFS_PENDING, OFS_STATUS, OFS_TOP_SOURCE};
    wire logic pend   = |(EVENT_IN & en_q & MASK_SOURCES);
    wire logic [DATA_W-1:0] wm = PWDATA & ~MASK_RSVD & {{8{PSTRB[3]}},
        {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
    assign en_d = !(wr_hit && is_en) ? en_q
                : is_set ? en_q | wm : en_q & ~wm;
    always_ff @(posedge SYS_CLK) begin
        en_q <= RESET ? MASK_RESET : en_d;
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);

    a_irq_follow: assert property ($past(CLK_EN) |-> IRQ_OUT ==
        ($past(en_q[BIT_GLOBAL_GATE]) && $past(pend)))
        else $error("irq differs from gated events");
    a_gate_off: assert property ($past(CLK_EN) &&
        !$past(en_q[BIT_GLOBAL_GATE]) |-> !IRQ_OUT)
        else $error("irq raised with global gate off");
    a_irq_needs_pair: assert property ($past(CLK_EN) && IRQ_OUT
        |-> $past(pend)) else $error("irq without event and enable");
    a_read_both: assert property (PREADY && !PWRITE && is_en
        |-> PRDATA == en_q) else $error("read data is not the enables");
    a_rsvd_zero: assert property (PREADY && !PWRITE && is_en
        |-> (PRDATA & MASK_RSVD) == '0) else $error("reserved bit set");
    a_ready_two: assert property (PSEL && CLK_EN
        && $rose(PENABLE) |-> !PREADY ##1 !PREADY ##1 PREADY)
        else $error("answer late");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (PREADY && !mapped
        |-> PSLVERR && PRDATA == '0) else $error("unmapped not refused");
    a_mapped_ok: assert property (PREADY && mapped |-> !PSLVERR)
        else $error("error on a mapped address");
endmodule : hmg_chk

bind hmg_top hmg_chk u_hmg_chk (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .CLK_EN(CLK_EN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .EVENT_IN(EVENT_IN), .IRQ_OUT(IRQ_OUT)
);

`default_nettype wire

// >>> bench/testbench.sv
/* testbench: apb-driven checks of the enable register and irq gate.
   assumes: hmg_top answers each transfer by itself; no other master. */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import hmg_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              ce = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [3:0]        pstrb = 4'hf;
    logic [DATA_W-1:0] evt = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic [DATA_W-1:0] rd;
    logic              er;
    int                err_count = 0;
    int                n_compared = 0;
    // status word with irq, gate, any-pending and top-valid all set
    localparam logic [DATA_W-1:0] STS_ALL = (32'h1 << STS_IRQ)
        | (32'h1 << STS_GATE) | (32'h1 << STS_ANY) | (32'h1 << STS_VLD);

    always #10 clk = ~clk;

    hmg_top u_hmg_top (
        .SYS_CLK(clk), .RESET(rst), .CLK_EN(ce), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EVENT_IN(evt),
        .IRQ_OUT(irq)
    );

    // ----------------
    // bus and compare
    // ----------------
    task automatic chk(input logic [DATA_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // waits for pready however long; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, '0, 4'hf);
        chk(rd, e);
    endtask : rdchk

    task automatic ev(input logic [DATA_W-1:0] v);
        @(posedge clk);
        evt <= v;
    endtask : ev

    // sampled mid-cycle so the edge's update has landed
    task automatic irq_chk(input logic e);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask : irq_chk

    task automatic tend(input string s);
        $display("test %s done", s);
    endtask : tend

    task automatic conclude;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude

    // ----------------
    // tests
    // ----------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFS_ENABLE_CLEAR, MASK_RESET);
        tend("reset");
        wr(OFS_ENABLE_SET, 32'hffff_ffff);
        rdchk(OFS_ENABLE_SET, ~MASK_RSVD);
        wr(OFS_ENABLE_CLEAR, 32'h0000_00ff);
        rdchk(OFS_ENABLE_CLEAR, 32'hefff_8300);
        apb(1'b1, OFS_ENABLE_CLEAR, 32'hffff_ffff, 4'h2);
        rdchk(OFS_ENABLE_SET, 32'hefff_0000);
        tend("set_clear");
        apb(1'b0, 12'h090, '0, 4'hf);
        chk({31'h0, er}, 32'h1);
        chk(rd, '0);
        wr(12'h090, 32'hffff_ffff);
        wr(OFS_PENDING, 32'hffff_ffff);
        rdchk(OFS_ENABLE_SET, 32'hefff_0000);
        tend("unmapped");
        wr(OFS_ENABLE_CLEAR, 32'hffff_ffff);
        wr(OFS_ENABLE_SET, MASK_GATE);
        for (int i = 0; i < 32; i++) begin
            if (MASK_SOURCES[i]) begin
                ev(32'h1 << i);
                irq_chk(1'b0);
                wr(OFS_ENABLE_SET, 32'h1 << i);
                irq_chk(1'b1);
                ev('0);
                irq_chk(1'b0);
                wr(OFS_ENABLE_CLEAR, 32'h1 << i);
            end
        end
        tend("sources");
        wr(OFS_ENABLE_SET, 32'hffff_ffff);
        ev(MASK_RSVD);
        irq_chk(1'b0);
        ev(32'hffff_ffff);
        irq_chk(1'b1);
        rdchk(OFS_PENDING, MASK_SOURCES);
        rdchk(OFS_STATUS, STS_ALL);
        rdchk(OFS_TOP_SOURCE, DATA_W'(BIT_MAKER));
        wr(OFS_ENABLE_CLEAR, MASK_GATE);
        irq_chk(1'b0);
        wr(OFS_ENABLE_SET, MASK_GATE);
        @(posedge clk);
        ce <= 1'b0;
        ev('0);
        irq_chk(1'b1);
        @(posedge clk);
        ce <= 1'b1;
        irq_chk(1'b0);
        tend("gate");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(OFS_ENABLE_SET, MASK_RESET);
        tend("second_reset");
        conclude();
    end

    initial begin
        #200000;
        err_count++;
        conclude();
    end
endmodule : testbench

`default_nettype wire
